// [shared/cfgset_pkg.sv]
package cfgset_pkg;
  // Configuration set content: a gain code plus auto-function flags
  localparam int GAIN_W = 8;
  localparam int SLOT_W = 2;
  localparam int FAC_W = 2;
  localparam int LUT_W = 8;

  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic gain_auto;
    logic exposure_auto;
    logic color_opt;
  } cfgset_set_t;

  localparam int SET_W = $bits(cfgset_set_t);

  // Slot selector encodings
  localparam logic [SLOT_W-1:0] SLOT_DEFAULT = 2'h0;
  localparam logic [SLOT_W-1:0] SLOT_USER1 = 2'h1;
  localparam logic [SLOT_W-1:0] SLOT_USER2 = 2'h2;
  localparam logic [SLOT_W-1:0] SLOT_USER3 = 2'h3;
  localparam int USER_SLOTS = 3;

  // Factory setup choices
  localparam logic [FAC_W-1:0] FAC_STANDARD = 2'h0;
  localparam logic [FAC_W-1:0] FAC_HIGH_GAIN = 2'h1;
  localparam logic [FAC_W-1:0] FAC_AUTO = 2'h2;
  localparam logic [FAC_W-1:0] FAC_COLOR = 2'h3;

  // Gain codes: one code step is taken as 1 dB
  localparam logic [GAIN_W-1:0] GAIN_LOW = 8'h00;
  localparam logic [GAIN_W-1:0] GAIN_PLUS_6DB = 8'h06;

  localparam cfgset_set_t FAC_SET_STANDARD = '{GAIN_LOW, 1'b0, 1'b0, 1'b0};
  localparam cfgset_set_t FAC_SET_HIGH_GAIN = '{GAIN_PLUS_6DB, 1'b0, 1'b0, 1'b0};
  localparam cfgset_set_t FAC_SET_AUTO = '{GAIN_LOW, 1'b1, 1'b1, 1'b0};
  localparam cfgset_set_t FAC_SET_COLOR = '{GAIN_LOW, 1'b0, 1'b0, 1'b1};
endpackage

// [verilog/cfgset_manager.sv]
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Host parameter writes go to the active set, which alone drives the camera outputs.
// [RULE2] The active set is volatile and is rebuilt on every reset.
// [RULE3] Four factory setups are fixed constants that survive reset and cannot be written.
// [RULE4] The standard setup has low gain and every auto function off.
// [RULE5] The high-gain setup equals standard but with gain at plus six decibels.
// [RULE6] The auto setup equals standard but with gain and exposure auto on, gain kept minimal.
// [RULE7] The factory setup choice is kept in storage that reset does not clear.
// [RULE8] Three user slots keep saved sets across reset.
// [RULE9] After every reset the chosen startup set is copied into the active set.
// [RULE10] A save command copies the active set into the selected user slot.
// [RULE11] The luminance lookup-table value is never saved into a user slot.
// [RULE12] The factory setup choice starts out as the standard setup.
// [RULE13] The host picks one of four factory setups for the default set.
// [RULE14] The host changes the factory setup choice only while the camera is idle.
// [RULE15] The default set can be loaded into the active set while running.
// [RULE16] A load command copies the selected slot or default set into the active set.
// [RULE17] A factory setup change requested while acquisition is busy is ignored.
module cfgset_manager (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic param_wr,
  input wire cfgset_pkg::cfgset_set_t param_wdata,
  input wire logic lut_wr,
  input wire logic [cfgset_pkg::LUT_W-1:0] lut_wdata,
  input wire logic [cfgset_pkg::SLOT_W-1:0] user_slot_select,
  input wire logic save_active_to_slot,
  input wire logic load_slot_to_active,
  input wire logic [cfgset_pkg::SLOT_W-1:0] startup_select,
  input wire logic startup_select_wr,
  input wire logic [cfgset_pkg::FAC_W-1:0] factory_setup_choice,
  input wire logic factory_setup_wr,
  input wire logic acq_busy,
  output cfgset_pkg::cfgset_set_t active_set,
  output logic [cfgset_pkg::LUT_W-1:0] active_lut,
  output logic [cfgset_pkg::FAC_W-1:0] factory_choice_state,
  output logic [cfgset_pkg::SLOT_W-1:0] startup_state,
  output logic choice_refused
);
  import cfgset_pkg::*;

  function automatic cfgset_set_t factory_set(input logic [FAC_W-1:0] sel);
    unique case (sel)
      FAC_STANDARD: factory_set = FAC_SET_STANDARD; // [RULE4]
      FAC_HIGH_GAIN: factory_set = FAC_SET_HIGH_GAIN; // [RULE5]
      FAC_AUTO: factory_set = FAC_SET_AUTO; // [RULE6]
      FAC_COLOR: factory_set = FAC_SET_COLOR;
    endcase
  endfunction

  // Non-volatile part: these models have no reset, standing in for storage
  // that keeps its contents across a device reset. Power-up value set once.
  logic [FAC_W-1:0] fac_choice_r = FAC_STANDARD; // [RULE12]
  logic [FAC_W-1:0] fac_choice_nxt;
  logic [SLOT_W-1:0] startup_r = SLOT_DEFAULT;
  logic [SLOT_W-1:0] startup_nxt;
  cfgset_set_t user_mem_r [USER_SLOTS] = '{default: FAC_SET_STANDARD};
  cfgset_set_t user_mem_nxt [USER_SLOTS];
  logic save_en;
  logic [SLOT_W-1:0] save_idx;

  // Volatile part
  cfgset_set_t active_r;
  cfgset_set_t active_nxt;
  logic [LUT_W-1:0] lut_r;
  logic [LUT_W-1:0] lut_nxt;
  logic boot_r;
  logic boot_nxt;
  logic refuse_r;
  logic refuse_nxt;

  function automatic logic is_user_slot(input logic [SLOT_W-1:0] sel);
    is_user_slot = (sel != SLOT_DEFAULT);
  endfunction

  function automatic logic [SLOT_W-1:0] slot_index(input logic [SLOT_W-1:0] sel);
    slot_index = sel - SLOT_USER1;
  endfunction

  // Factory setup choice, also taken while reset is held
  always_comb begin
    fac_choice_nxt = fac_choice_r;
    refuse_nxt = 1'b0;
    if (factory_setup_wr) begin
      if (acq_busy) begin
        refuse_nxt = 1'b1; // [RULE17]
      end else begin
        fac_choice_nxt = factory_setup_choice; // [RULE7] [RULE13] [RULE14]
      end
    end
  end

  always_ff @(posedge clock) begin
    fac_choice_r <= fac_choice_nxt;
  end

  // Startup set choice
  always_comb begin
    startup_nxt = startup_r;
    if (startup_select_wr) begin
      startup_nxt = startup_select;
    end
  end

  always_ff @(posedge clock) begin
    startup_r <= startup_nxt;
  end

  // User slots; a save reads the active set as it was before this edge
  always_comb begin
    save_en = save_active_to_slot && is_user_slot(user_slot_select);
    save_idx = slot_index(user_slot_select);
    for (int i = 0; i < USER_SLOTS; i++) begin
      user_mem_nxt[i] = user_mem_r[i];
      if (save_en && (save_idx == SLOT_W'(i))) begin
        user_mem_nxt[i] = active_r; // [RULE8] [RULE10] [RULE11]
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < USER_SLOTS; i++) begin
      user_mem_r[i] <= user_mem_nxt[i];
    end
  end

  function automatic cfgset_set_t pick_set(input logic [SLOT_W-1:0] sel,
                                           input logic [FAC_W-1:0] fac,
                                           input cfgset_set_t u1,
                                           input cfgset_set_t u2,
                                           input cfgset_set_t u3);
    unique case (sel)
      SLOT_DEFAULT: pick_set = factory_set(fac); // [RULE3]
      SLOT_USER1: pick_set = u1;
      SLOT_USER2: pick_set = u2;
      SLOT_USER3: pick_set = u3;
    endcase
  endfunction

  // Active set: startup load outranks a host load, which outranks a write
  always_comb begin
    active_nxt = active_r;
    if (boot_r) begin
      // First cycle after reset release loads the startup set
      active_nxt = pick_set(startup_r, fac_choice_r, user_mem_r[0], user_mem_r[1],
                            user_mem_r[2]); // [RULE9]
    end else if (load_slot_to_active) begin
      active_nxt = pick_set(user_slot_select, fac_choice_r, user_mem_r[0],
                            user_mem_r[1], user_mem_r[2]); // [RULE15] [RULE16]
    end else if (param_wr) begin
      active_nxt = param_wdata; // [RULE1]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      active_r <= FAC_SET_STANDARD; // [RULE2]
    end else begin
      active_r <= active_nxt;
    end
  end

  // Lookup-table value: volatile and never part of a saved set
  always_comb begin
    lut_nxt = lut_r;
    if (lut_wr) begin
      lut_nxt = lut_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lut_r <= '0; // [RULE11]
    end else begin
      lut_r <= lut_nxt;
    end
  end

  // Boot flag lasts one cycle, so the startup load happens exactly once
  always_comb begin
    boot_nxt = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= boot_nxt;
    end
  end

  // Refusal pulse is volatile status
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      refuse_r <= 1'b0;
    end else begin
      refuse_r <= refuse_nxt;
    end
  end

  // Every output is a register

  assign active_set = active_r;
  assign active_lut = lut_r;
  assign factory_choice_state = fac_choice_r;
  assign startup_state = startup_r;
  assign choice_refused = refuse_r;
endmodule

// [testbench/cfgset_manager_monitor.sv]
`timescale 1ns/1ps
module cfgset_manager_monitor
  import cfgset_pkg::*;
(
  input logic clock, input logic rst_n, input logic param_wr,
  input cfgset_pkg::cfgset_set_t param_wdata, input logic load_slot_to_active,
  input logic [SLOT_W-1:0] user_slot_select, input logic startup_select_wr,
  input logic [FAC_W-1:0] factory_setup_choice, input logic factory_setup_wr,
  input logic acq_busy, input cfgset_pkg::cfgset_set_t active_set,
  input logic [LUT_W-1:0] active_lut, input logic [FAC_W-1:0] factory_choice_state,
  input logic [SLOT_W-1:0] startup_state, input logic choice_refused
);
  localparam cfgset_set_t FS [4] = '{FAC_SET_STANDARD, FAC_SET_HIGH_GAIN, FAC_SET_AUTO, FAC_SET_COLOR};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_busy_wr; factory_setup_wr && acq_busy; endsequence
  property p_refuse; s_busy_wr |=> choice_refused && $stable(factory_choice_state); endproperty
  a_refuse: assert property (p_refuse) else $error("busy choice not refused");
  property p_quiet; !(factory_setup_wr && acq_busy) |=> !choice_refused; endproperty
  a_quiet: assert property (p_quiet) else $error("stray refusal pulse");
  property p_take;
    factory_setup_wr && !acq_busy |=> factory_choice_state == $past(factory_setup_choice);
  endproperty
  a_take: assert property (p_take) else $error("idle choice not taken");
  property p_start;
    $rose(rst_n) && startup_state == SLOT_DEFAULT |=> active_set == FS[$past(factory_choice_state)];
  endproperty
  a_start: assert property (p_start) else $error("startup default not loaded");
  property p_param;
    param_wr && !load_slot_to_active && !$rose(rst_n) |=> active_set == $past(param_wdata);
  endproperty
  a_param: assert property (p_param) else $error("parameter write lost");
  property p_def;
    load_slot_to_active && user_slot_select == SLOT_DEFAULT && !$rose(rst_n)
      |=> active_set == FS[$past(factory_choice_state)];
  endproperty
  a_def: assert property (p_def) else $error("default load wrong");
  property p_vol; disable iff (1'b0) !rst_n |=> active_lut == 8'h00 && !choice_refused; endproperty
  a_vol: assert property (p_vol) else $error("volatile state kept in reset");
  property p_nv;
    disable iff (1'b0) !factory_setup_wr && !startup_select_wr
      |=> $stable(factory_choice_state) && $stable(startup_state);
  endproperty
  a_nv: assert property (p_nv) else $error("stored choice changed");
endmodule
bind cfgset_manager cfgset_manager_monitor u_cfgset_manager_monitor (.clock, .rst_n, .param_wr,
  .param_wdata, .load_slot_to_active, .user_slot_select, .startup_select_wr, .factory_setup_choice,
  .factory_setup_wr, .acq_busy, .active_set, .active_lut, .factory_choice_state, .startup_state,
  .choice_refused);

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import cfgset_pkg::*;
  logic clock = 0, rst_n = 0, acq_busy = 0, rf;
  logic [5:0] strb = 6'h00;
  wire param_wr, lut_wr, save_active_to_slot, load_slot_to_active, factory_setup_wr, startup_select_wr;
  cfgset_set_t param_wdata = '0, active_set;
  logic [LUT_W-1:0] lut_wdata = 8'h00, active_lut;
  logic [SLOT_W-1:0] user_slot_select = 2'h0, startup_select = 2'h0, startup_state;
  logic [FAC_W-1:0] factory_setup_choice = 2'h0, factory_choice_state;
  logic choice_refused;
  int error_cnt = 0, checked = 0;
  // Expected setups built from the setup descriptions, not the package table
  cfgset_set_t fac_tab [4] = '{'{8'h00, 1'b0, 1'b0, 1'b0}, '{8'h06, 1'b0, 1'b0, 1'b0},
    '{8'h00, 1'b1, 1'b1, 1'b0}, '{8'h00, 1'b0, 1'b0, 1'b1}};
  cfgset_set_t usr [3];
  assign {param_wr, lut_wr, save_active_to_slot, load_slot_to_active, factory_setup_wr,
    startup_select_wr} = strb;
  cfgset_manager u_cfgset_manager (.*);
  always #2.5 clock = ~clock;
  task pulse(input logic [5:0] m);
    @(negedge clock) strb = m;
    @(negedge clock) strb = 6'h00;
    rf = choice_refused;
  endtask
  task do_reset;
    @(negedge clock) rst_n = 0;
    repeat (3) @(negedge clock);
    rst_n = 1;
    repeat (2) @(negedge clock);
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] v);
    checked++;
    if (v !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, v);
    end
  endtask
  task final_report;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    do_reset();
    chk("boot", 16'(fac_tab[0]), 16'(active_set));
    chk("ship", 16'h0000, 16'(factory_choice_state));
    for (int f = 0; f < 4; f++) begin
      factory_setup_choice = 2'(f);
      pulse(6'h02);
      chk("choice", 16'(f), 16'(factory_choice_state));
      pulse(6'h04);
      chk("default", 16'(fac_tab[f]), 16'(active_set));
    end
    acq_busy = 1;
    factory_setup_choice = FAC_HIGH_GAIN;
    pulse(6'h02);
    chk("refused", 16'h0001, 16'(rf));
    chk("kept", 16'(FAC_COLOR), 16'(factory_choice_state));
    acq_busy = 0;
    for (int s = 1; s < 4; s++) begin
      usr[s-1] = '{8'(16 * s + 1), 1'b1, s[0], 1'b0};
      param_wdata = usr[s-1];
      pulse(6'h20);
      chk("param", 16'(usr[s-1]), 16'(active_set));
      user_slot_select = 2'(s);
      pulse(6'h08);
    end
    param_wdata = fac_tab[1];
    pulse(6'h20);
    user_slot_select = SLOT_DEFAULT;
    pulse(6'h08);
    for (int s = 1; s < 4; s++) begin
      user_slot_select = 2'(s);
      pulse(6'h04);
      chk("slot", 16'(usr[s-1]), 16'(active_set));
    end
    lut_wdata = 8'ha5;
    startup_select = SLOT_USER3;
    pulse(6'h11);
    chk("lut", 16'h00a5, 16'(active_lut));
    chk("startup_sel", 16'(SLOT_USER3), 16'(startup_state));
    do_reset();
    chk("startup", 16'(usr[2]), 16'(active_set));
    chk("lut_lost", 16'h0000, 16'(active_lut));
    chk("fac_kept", 16'(FAC_COLOR), 16'(factory_choice_state));
    chk("startup_kept", 16'(SLOT_USER3), 16'(startup_state));
    final_report();
  end
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule
